// [core/bst_map.svh]
/*
  constants for the boundary scan test port: instruction codes, register
  lengths, reset values. assumes inclusion by bare name.
*/
`ifndef BST_MAP_SVH
`define BST_MAP_SVH
`define BST_IR_LEN        3
`define BST_IR_CAPTURE    3'h1
`define BST_CODE_EXTEST   3'h0
`define BST_CODE_IDCODE   3'h1
`define BST_CODE_SAMPLEZ  3'h2
`define BST_CODE_RSVD_A   3'h3
`define BST_CODE_SAMPLE   3'h4
`define BST_CODE_PRIVATE  3'h5
`define BST_CODE_RSVD_B   3'h6
`define BST_CODE_BYPASS   3'h7
`define BST_ID_LEN        32
`define BST_ID_USED       12
`define BST_ID_VALUE      12'ha53 // arbitrary vendor code, presence bit set
`define BST_BSR_LEN       8
`define BST_PIN_LEN       6
`define BST_BSR_DEFAULT   8'hff
`define BST_TLR_ONES      5
`endif

// [core/bst_pkg.sv]
/*
  types for the boundary scan test port.
  assumes bst_map.svh is on the include path.
*/
`include "bst_map.svh"
package bst_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } bst_state_t;
  typedef enum logic [1:0] {PATH_BYP, PATH_ID, PATH_BSR} bst_path_t;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_pins_t;
endpackage

// [core/bst_bsr.sv]
/*
  boundary scan register: capture, shift and falling-edge update latch.
  assumes tck edge strobes come from the tap on the same clock.
*/
`include "bst_map.svh"
module bst_bsr (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_ce,
  input  wire logic                      i_capture,
  input  wire logic                      i_shift,
  input  wire logic                      i_update,
  input  wire logic                      i_tdi,
  input  wire logic [`BST_PIN_LEN-1:0]   i_pins,
  output logic                           o_sout,
  output logic      [`BST_PIN_LEN-1:0]   o_upd
);
  logic [`BST_BSR_LEN-1:0] sh_reg;
  logic [`BST_BSR_LEN-1:0] sh_next;
  logic [`BST_PIN_LEN-1:0] upd_reg;
  logic [`BST_PIN_LEN-1:0] upd_next;
  localparam logic [`BST_BSR_LEN-1:0] DEF = `BST_BSR_DEFAULT;

  always_comb begin
    sh_next  = sh_reg;
    upd_next = upd_reg;
    if (i_capture) begin
      // unbonded cells take their default
      sh_next = {DEF[`BST_BSR_LEN-1:`BST_PIN_LEN], i_pins};
    end else if (i_shift) begin
      sh_next = {i_tdi, sh_reg[`BST_BSR_LEN-1:1]};
    end
    if (i_update) begin
      upd_next = sh_reg[`BST_PIN_LEN-1:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      sh_reg  <= `BST_BSR_DEFAULT;
      upd_reg <= '0;
    end else if (i_ce) begin
      sh_reg  <= sh_next;
      upd_reg <= upd_next;
    end
  end

  assign o_sout = sh_reg[0];
  assign o_upd  = upd_reg;
endmodule

// [core/bst_tap.sv]
/*
  test access port of the memory: tap state machine, instruction register,
  bypass, identification and boundary paths, pin drive control.
  assumes tck/tms/tdi arrive asynchronously and are oversampled by i_sys_clk.
*/
// Notes on behaviour
// - capture-ir loads the low two instruction bits with 01.
// - in shift-ir the instruction register shifts between tdi and tdo.
// - new instruction takes effect only at update-ir.
// - three-bit codes, lsb first; 111 is bypass.
// - reserved codes 011 and 110 act as bypass.
// - sample/preload 100 captures pins and shifts boundary register.
// - boundary cells without a pin capture their fixed default.
// - code 000 decodes as extest on the boundary register.
// - under extest the memory inputs stay live.
// - under extest outputs drive boundary cells, updated on falling tck.
// - extest capture-dr loads pins and defaults in parallel.
// - idcode 001 captures the id rom and shifts it.
// - instruction resets to idcode at power-up and test-logic-reset.
// - float-sample 010 floats outputs and uses the boundary register.
// - id bits 31 to 12 unused, bit 0 presence, rest vendor code.
// - device_identification is 32 bits, lsb out first.
// - no reset pin; five tms ones reach test-logic-reset.
// - tms and tdi sampled on rising tck; tdo changes on falling tck.
// - bypass is one flip-flop.
`include "bst_map.svh"
module bst_tap #(
  parameter logic [`BST_ID_USED-1:0] ID_CODE = `BST_ID_VALUE // arbitrary value
) (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_ce,
  input  wire bst_pkg::bst_pins_t        i_jtag,
  input  wire logic [`BST_PIN_LEN-1:0]   i_pins,
  input  wire logic [`BST_PIN_LEN-1:0]   i_core_out,
  output logic                           o_tdo,
  output logic                           o_tdo_oe_n,
  output logic      [`BST_PIN_LEN-1:0]   o_pin_out,
  output logic                           o_pin_oe_n,
  output logic      [`BST_IR_LEN-1:0]    o_instr
);
  // three-stage sampling of the tap pins
  logic [2:0] tck_s;
  logic [2:0] tms_s;
  logic [2:0] tdi_s;
  logic       tck_q;
  logic       tck_q_next;
  logic       rise;
  logic       fall;

  bst_pkg::bst_state_t        st_reg;
  bst_pkg::bst_state_t        st_next;
  logic [`BST_IR_LEN-1:0]     irs_reg;
  logic [`BST_IR_LEN-1:0]     irs_next;
  logic [`BST_IR_LEN-1:0]     ir_reg;
  logic [`BST_IR_LEN-1:0]     ir_next;
  logic                       byp_reg;
  logic                       byp_next;
  logic [`BST_ID_LEN-1:0]     id_reg;
  logic [`BST_ID_LEN-1:0]     id_next;
  logic                       tdo_reg;
  logic                       tdo_next;
  logic                       tdo_oe_n_reg;
  logic                       tdo_oe_n_next;
  logic [`BST_PIN_LEN-1:0]    pout_reg;
  logic [`BST_PIN_LEN-1:0]    pout_next;
  logic                       poe_n_reg;
  logic                       poe_n_next;
  bst_pkg::bst_path_t         path;
  logic                       tms;
  logic                       tdi;
  logic                       bsr_out;
  logic [`BST_PIN_LEN-1:0]    bsr_upd;
  logic                       sh_dr;
  logic                       is_bsr;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tck_s <= 3'h0;
      tms_s <= 3'h7;
      tdi_s <= 3'h7;
    end else if (i_ce) begin
      tck_s <= {tck_s[1:0], i_jtag.tck};
      tms_s <= {tms_s[1:0], i_jtag.tms};
      tdi_s <= {tdi_s[1:0], i_jtag.tdi};
    end
  end

  always_comb begin
    tck_q_next = tck_q;
    if (tck_s[2] == tck_s[1]) begin
      tck_q_next = tck_s[2];
    end
  end
  assign rise = tck_q_next & ~tck_q;
  assign fall = ~tck_q_next & tck_q;
  assign tms  = tms_s[2];
  assign tdi  = tdi_s[2];

  // instruction decode; unlisted codes fall to bypass
  always_comb begin
    case (ir_reg)
      `BST_CODE_EXTEST:  path = bst_pkg::PATH_BSR;
      `BST_CODE_SAMPLEZ: path = bst_pkg::PATH_BSR;
      `BST_CODE_SAMPLE:  path = bst_pkg::PATH_BSR;
      `BST_CODE_IDCODE:  path = bst_pkg::PATH_ID;
      `BST_CODE_RSVD_A:  path = bst_pkg::PATH_BYP;
      `BST_CODE_RSVD_B:  path = bst_pkg::PATH_BYP;
      `BST_CODE_PRIVATE: path = bst_pkg::PATH_BYP;
      default:           path = bst_pkg::PATH_BYP;
    endcase
  end
  assign is_bsr = (path == bst_pkg::PATH_BSR);
  assign sh_dr  = (st_reg == bst_pkg::SH_DR);

  always_comb begin
    st_next  = st_reg;
    irs_next = irs_reg;
    ir_next  = ir_reg;
    byp_next = byp_reg;
    id_next  = id_reg;
    if (rise) begin
      case (st_reg)
        bst_pkg::TLR:    st_next = tms ? bst_pkg::TLR    : bst_pkg::RTI;
        bst_pkg::RTI:    st_next = tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
        bst_pkg::SEL_DR: st_next = tms ? bst_pkg::SEL_IR : bst_pkg::CAP_DR;
        bst_pkg::CAP_DR: st_next = tms ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
        bst_pkg::SH_DR:  st_next = tms ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
        bst_pkg::EX1_DR: st_next = tms ? bst_pkg::UPD_DR : bst_pkg::PA_DR;
        bst_pkg::PA_DR:  st_next = tms ? bst_pkg::EX2_DR : bst_pkg::PA_DR;
        bst_pkg::EX2_DR: st_next = tms ? bst_pkg::UPD_DR : bst_pkg::SH_DR;
        bst_pkg::UPD_DR: st_next = tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
        bst_pkg::SEL_IR: st_next = tms ? bst_pkg::TLR    : bst_pkg::CAP_IR;
        bst_pkg::CAP_IR: st_next = tms ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
        bst_pkg::SH_IR:  st_next = tms ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
        bst_pkg::EX1_IR: st_next = tms ? bst_pkg::UPD_IR : bst_pkg::PA_IR;
        bst_pkg::PA_IR:  st_next = tms ? bst_pkg::EX2_IR : bst_pkg::PA_IR;
        bst_pkg::EX2_IR: st_next = tms ? bst_pkg::UPD_IR : bst_pkg::SH_IR;
        bst_pkg::UPD_IR: st_next = tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
        default:         st_next = bst_pkg::TLR;
      endcase
      case (st_reg)
        bst_pkg::TLR: ir_next = `BST_CODE_IDCODE;
        bst_pkg::CAP_IR: begin
          irs_next = {irs_reg[`BST_IR_LEN-1:2], 2'(`BST_IR_CAPTURE)};
        end
        bst_pkg::SH_IR: begin
          irs_next = {tdi, irs_reg[`BST_IR_LEN-1:1]};
        end
        bst_pkg::CAP_DR: begin
          byp_next = 1'b0;
          if (path == bst_pkg::PATH_ID) begin
            // presence bit lands in bit 0 of the code
            id_next = {{(`BST_ID_LEN-`BST_ID_USED){1'b0}}, ID_CODE};
          end
        end
        bst_pkg::SH_DR: begin
          byp_next = tdi;
          if (path == bst_pkg::PATH_ID) begin
            id_next = {tdi, id_reg[`BST_ID_LEN-1:1]};
          end
        end
        default: ;
      endcase
    end
    if (fall && st_reg == bst_pkg::UPD_IR) begin
      ir_next = irs_reg;
    end
  end

  // tdo and pin values change on falling tck; float follows the instruction
  always_comb begin
    tdo_next      = tdo_reg;
    tdo_oe_n_next = tdo_oe_n_reg;
    pout_next     = pout_reg;
    poe_n_next    = (ir_next == `BST_CODE_SAMPLEZ);
    if (fall) begin
      tdo_oe_n_next = ~(sh_dr || st_reg == bst_pkg::SH_IR);
      if (st_reg == bst_pkg::SH_IR) begin
        tdo_next = irs_reg[0];
      end else begin
        case (path)
          bst_pkg::PATH_ID:  tdo_next = id_reg[0];
          bst_pkg::PATH_BSR: tdo_next = bsr_out;
          default:           tdo_next = byp_reg;
        endcase
      end
      // inputs to the core are never gated here
      if (ir_next == `BST_CODE_EXTEST) begin
        pout_next = bsr_upd;
      end else begin
        pout_next = i_core_out;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tck_q        <= 1'b0;
      st_reg       <= bst_pkg::TLR;
      irs_reg      <= `BST_CODE_IDCODE;
      ir_reg       <= `BST_CODE_IDCODE;
      byp_reg      <= 1'b0;
      id_reg       <= '0;
      tdo_reg      <= 1'b0;
      tdo_oe_n_reg <= 1'b1;
      pout_reg     <= '0;
      poe_n_reg    <= 1'b0;
    end else if (i_ce) begin
      tck_q        <= tck_q_next;
      st_reg       <= st_next;
      irs_reg      <= irs_next;
      ir_reg       <= ir_next;
      byp_reg      <= byp_next;
      id_reg       <= id_next;
      tdo_reg      <= tdo_next;
      tdo_oe_n_reg <= tdo_oe_n_next;
      pout_reg     <= pout_next;
      poe_n_reg    <= poe_n_next;
    end
  end

  bst_bsr u_bsr (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_capture (rise && st_reg == bst_pkg::CAP_DR && is_bsr),
    .i_shift   (rise && sh_dr && is_bsr),
    .i_update  (fall && st_reg == bst_pkg::UPD_DR && is_bsr),
    .i_tdi     (tdi),
    .i_pins    (i_pins),
    .o_sout    (bsr_out),
    .o_upd     (bsr_upd)
  );

  assign o_tdo      = tdo_reg;
  assign o_tdo_oe_n = tdo_oe_n_reg;
  assign o_pin_out  = pout_reg;
  assign o_pin_oe_n = poe_n_reg;
  assign o_instr    = ir_reg;
endmodule

// [tb/bst_tap_chk.sv]
/*
  checker on the test port outputs.
  assumes it is bound onto bst_tap.
*/
module bst_tap_chk (
  input wire logic               i_sys_clk,
  input wire logic               i_sys_rst,
  input wire bst_pkg::bst_pins_t i_jtag,
  input wire logic               o_tdo,
  input wire logic               o_tdo_oe_n,
  input wire logic [5:0]         o_pin_out,
  input wire logic               o_pin_oe_n,
  input wire logic [2:0]         o_instr
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  logic       tck_reg;
  logic [2:0] ones_reg;
  logic [2:0] ones_next;
  // run of tms ones at tck rises
  always_comb begin
    ones_next = ones_reg;
    if (i_jtag.tck && !tck_reg) begin
      ones_next = !i_jtag.tms ? 3'h0 : (ones_reg == 3'h5) ? ones_reg : ones_reg + 3'h1;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    tck_reg  <= i_jtag.tck;
    ones_reg <= i_sys_rst ? 3'h0 : ones_next;
  end
  a_reset_idcode: assert property ($fell(i_sys_rst) |-> o_instr == 3'h1 && o_tdo_oe_n)
    else $error("instruction not idcode after reset");
  a_tlr_idcode: assert property (ones_reg == 3'h4 && ones_next == 3'h5 |-> ##[1:20] o_instr == 3'h1)
    else $error("five tms ones did not restore idcode");
  a_tlr_quiet: assert property (ones_reg == 3'h5 && $past(ones_reg) == 3'h5 |-> o_tdo_oe_n)
    else $error("tdo driven in reset state");
  a_instr_tck_low: assert property ($changed(o_instr) && o_instr != 3'h1 |-> !i_jtag.tck)
    else $error("instruction changed while tck high");
  a_tdo_tck_low: assert property ($changed(o_tdo) || $changed(o_tdo_oe_n) |-> !i_jtag.tck)
    else $error("tdo changed while tck high");
  a_pin_upd_low: assert property ($changed(o_pin_out) && o_instr == 3'h0 && $past(o_instr) == 3'h0
    |-> !i_jtag.tck)
    else $error("boundary drive changed while tck high");
  a_float_oe: assert property (o_instr == 3'h2 && $past(o_instr) == 3'h2 |-> o_pin_oe_n)
    else $error("outputs driven under float sample");
  a_drive_oe: assert property (o_instr != 3'h2 && $past(o_instr) != 3'h2 |-> !o_pin_oe_n)
    else $error("outputs floated outside float sample");
endmodule
bind bst_tap bst_tap_chk chk_u (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_jtag(i_jtag),
  .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n),
  .o_instr(o_instr));

// [tb/bst_ctl_model.sv]
/*
  scan controller model driving tck, tms and tdi.
  assumes tdo comes from the port under test.
*/
module bst_ctl_model (
  output bst_pkg::bst_pins_t o_jtag,
  input  wire logic          i_tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial o_jtag = 3'h3; // tck low, pulled-up tms and tdi
  // one tck period, tdo taken just before the rise
  task step(input logic tms, input logic tdi, output logic tdo);
    o_jtag.tms <= tms;
    o_jtag.tdi <= tdi;
    #31.25 tdo = i_tdo;
    o_jtag.tck <= 1'b1;
    #62.5 o_jtag.tck <= 1'b0;
    #31.25;
  endtask
  task tlr();
    logic t;
    repeat (5) step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
  endtask
  // full ir or dr scan from idle back to idle
  task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic t;
    dout = '0;
    step(1'b1, 1'b1, t);
    if (ir) step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
    step(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
    // extra idle tck so the last update has reached the pins
    step(1'b0, 1'b1, t);
  endtask
endmodule

// [tb/sram_boundary_scan_tap_instructions_bench.sv]
/*
  self-checking bench for the scan port instructions.
  assumes the controller model and checker from tb/.
*/
`include "bst_map.svh"
module sram_boundary_scan_tap_instructions_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic               i_sys_clk = 1'b0;
  logic               i_sys_rst = 1'b1;
  logic [5:0]         pins      = 6'h00;
  logic [5:0]         core_out  = 6'h15;
  bst_pkg::bst_pins_t jtag;
  logic               tdo;
  logic               tdo_oe_n;
  logic               pin_oe_n;
  logic [5:0]         pin_out;
  logic [2:0]         instr;
  logic [31:0]        dout;
  int                 failures  = 0;
  int                 checks    = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  bst_tap dut_u (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1), .i_jtag(jtag),
    .i_pins(pins), .i_core_out(core_out), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n),
    .o_pin_out(pin_out), .o_pin_oe_n(pin_oe_n), .o_instr(instr));
  bst_ctl_model ctl_u (.o_jtag(jtag), .i_tdo(tdo));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task t_ident();
    check(instr, 3'h1);
    ctl_u.scan(1'b0, 32, '0, dout);
    check(dout, {20'h0_0000, `BST_ID_VALUE});
    $display("ident test done");
  endtask
  task t_ir();
    ctl_u.scan(1'b1, 3, 32'h0000_0007, dout);
    check(dout[1:0], 2'h1);
    check(instr, 3'h7);
    $display("instruction test done");
  endtask
  task t_bypass();
    logic [2:0] codes [4] = '{3'h3, 3'h5, 3'h6, 3'h7};
    foreach (codes[i]) begin
      ctl_u.scan(1'b1, 3, {29'h0, codes[i]}, dout);
      check(instr, codes[i]);
      ctl_u.scan(1'b0, 8, 32'h0000_00b5, dout);
      check(dout[7:0], 8'h6a);
    end
    $display("bypass test done");
  endtask
  task t_boundary();
    @(posedge i_sys_clk) pins <= 6'h2d;
    ctl_u.scan(1'b1, 3, 32'h0000_0004, dout);
    ctl_u.scan(1'b0, 8, 32'h0000_0096, dout);
    check(dout[7:0], 8'hed);
    check(pin_out, core_out);
    ctl_u.scan(1'b1, 3, '0, dout);
    check(instr, 3'h0);
    check(pin_out, 6'h16);
    @(posedge i_sys_clk) pins <= 6'h1b;
    ctl_u.scan(1'b0, 8, 32'h0000_003c, dout);
    check(dout[7:0], 8'hdb);
    check(pin_out, 6'h3c);
    $display("boundary test done");
  endtask
  task t_float();
    ctl_u.scan(1'b1, 3, 32'h0000_0002, dout);
    check(pin_oe_n, 1'b1);
    ctl_u.scan(1'b0, 8, '0, dout);
    check(dout[7:0], 8'hdb);
    ctl_u.tlr();
    check(instr, 3'h1);
    check(pin_oe_n, 1'b0);
    $display("float test done");
  endtask
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_sys_clk);
    ctl_u.tlr();
    t_ident();
    t_ir();
    t_bypass();
    t_boundary();
    t_float();
    print_verdict();
  end
  // watchdog well past the expected run
  initial begin
    #200_000;
    failures++;
    print_verdict();
  end
endmodule
